/* File: verilog/hqmc_pkg.sv */
// Shared constants of the harmonic mode classifier: ranges, thresholds, register map.
package hqmc_pkg;

  // ----------------------------------------------------------------
  // Analysis range and sub-band layout
  // ----------------------------------------------------------------
  localparam int unsigned COEF_W    = 16;           // Signed coefficient width.
  localparam int unsigned IDX_W     = 10;           // Coefficient index width.
  localparam int unsigned SUM_W     = 21;           // Sum of 32 magnitudes.
  localparam int unsigned BAND_LEN  = 32;           // Coefficients per sub-band.
  localparam int unsigned BAND_FIRST = 3;           // First analysed sub-band.
  localparam int unsigned BAND_SPLIT = 8;           // First sub-band of the high group.
  localparam int unsigned BAND_LAST = 16;           // Last analysed sub-band.
  localparam logic [IDX_W-1:0] IDX_FIRST = 10'h060; // Coefficient 96, 2400 Hz.
  localparam logic [IDX_W-1:0] IDX_LAST  = 10'h21F; // Coefficient 543, last below 13600 Hz.
  localparam logic [4:0] POS_LAST = 5'h1F;          // Last position inside a sub-band.

  // ----------------------------------------------------------------
  // Sharpness thresholds as integer ratios
  // ----------------------------------------------------------------
  // Sharp > 4.5 is 32*max > 4.5*sum, i.e. 64*max > 9*sum.
  // Sharp > 3.6 is 32*max > 3.6*sum, i.e. 80*max > 9*sum.
  localparam int unsigned CMP_W   = 26;
  localparam logic [6:0] LO_NUM   = 7'h40;          // 64.
  localparam logic [6:0] HI_NUM   = 7'h50;          // 80.
  localparam logic [3:0] SUM_DEN  = 4'h9;           // 9.
  localparam logic [COEF_W-1:0] PEAK_MIN = 16'h000A; // Peak must exceed 10.

  // ----------------------------------------------------------------
  // Frame decision constants
  // ----------------------------------------------------------------
  localparam logic [3:0] CNT_MAX      = 4'h8;       // Streak counter ceiling.
  localparam logic [3:0] CNT_RESET    = 4'h0;       // Streak counter after reset.
  localparam logic [3:0] TOTAL_MIN    = 4'hA;       // Low plus high count at least 10.
  localparam logic [3:0] HIGH_MIN     = 4'h5;       // High count must exceed 5.
  localparam logic [3:0] NONHARM_LIM  = 4'h5;       // Non-harmonic streak limit.

  // ----------------------------------------------------------------
  // Operating point encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] BW_NB  = 2'h0;
  localparam logic [1:0] BW_WB  = 2'h1;
  localparam logic [1:0] BW_SWB = 2'h2;
  localparam logic [1:0] BW_FB  = 2'h3;
  localparam logic [1:0] RATE_7K2  = 2'h0;
  localparam logic [1:0] RATE_8K0  = 2'h1;
  localparam logic [1:0] RATE_13K2 = 2'h2;
  localparam logic [1:0] RATE_16K4 = 2'h3;
  localparam logic [1:0] FS_8K  = 2'h0;
  localparam logic [1:0] FS_16K = 2'h1;
  localparam logic [1:0] FS_32K = 2'h2;
  localparam logic [1:0] FS_48K = 2'h3;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_FRAMES = 8'h08;
  localparam logic [1:0] CTRL_BW_RST   = 2'h2;      // Super-wideband.
  localparam logic [1:0] CTRL_RATE_RST = 2'h2;      // 13.2 kbps.
  localparam logic [1:0] CTRL_FS_RST   = 2'h2;      // 32 kHz.
  localparam int unsigned CTRL_BW_POS   = 0;
  localparam int unsigned CTRL_RATE_POS = 2;
  localparam int unsigned CTRL_FS_POS   = 4;
  localparam int unsigned CTRL_CLR_POS  = 8;

endpackage

/* File: verilog/hqmc_band_acc.sv */
// Sub-band accumulator: peak and sum of 32 coefficient magnitudes.
`timescale 1ns/100ps
module hqmc_band_acc (
  // Clock and reset.
  input  wire logic                             clk,
  input  wire logic                             rst,
  // Coefficient stream.
  input  wire logic                             coef_valid,
  input  wire logic [hqmc_pkg::IDX_W-1:0]       coef_index,
  input  wire logic signed [hqmc_pkg::COEF_W-1:0] coef_value,
  // Finished sub-band.
  output logic                                  band_done,
  output logic [4:0]                            band_num,
  output logic [hqmc_pkg::COEF_W-1:0]           band_peak,
  output logic [hqmc_pkg::SUM_W-1:0]            band_sum
);

  // ----------------------------------------------------------------
  // Magnitude and range selection
  // ----------------------------------------------------------------
  logic                           in_range;  // Coefficient lies in the analysed range.
  logic [hqmc_pkg::COEF_W-1:0]    mag;       // Absolute value; -32768 maps to 32768.
  logic                           first_pos; // First coefficient of a sub-band.
  logic [hqmc_pkg::COEF_W-1:0]    peak_reg;  // Running peak of the open sub-band.
  logic [hqmc_pkg::SUM_W-1:0]     sum_reg;   // Running sum of the open sub-band.
  logic [hqmc_pkg::COEF_W-1:0]    peak_next;
  logic [hqmc_pkg::SUM_W-1:0]     sum_next;

  // Coefficients outside 2400..13600 Hz never reach the sums.
  assign in_range  = coef_valid && (coef_index >= hqmc_pkg::IDX_FIRST)
                     && (coef_index <= hqmc_pkg::IDX_LAST);
  assign mag       = coef_value[hqmc_pkg::COEF_W-1] ? 16'(-coef_value) : coef_value;
  assign first_pos = (coef_index[4:0] == 5'h00);

  // Sub-band j covers indices 32j..32j+31, so a new band restarts on position 0.
  always_comb begin
    peak_next = first_pos ? mag : ((mag > peak_reg) ? mag : peak_reg);
    sum_next  = (first_pos ? '0 : sum_reg) + 21'(mag);
  end

  // ----------------------------------------------------------------
  // Running accumulation
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      peak_reg <= '0;
      sum_reg  <= '0;
    end else if (in_range) begin
      peak_reg <= peak_next;
      sum_reg  <= sum_next;
    end
  end

  // Publish the finished sub-band one cycle after its 32nd coefficient.
  always_ff @(posedge clk) begin
    if (rst) begin
      band_done <= 1'b0;
      band_num  <= 5'h00;
      band_peak <= '0;
      band_sum  <= '0;
    end else begin
      band_done <= in_range && (coef_index[4:0] == hqmc_pkg::POS_LAST);
      if (in_range && (coef_index[4:0] == hqmc_pkg::POS_LAST)) begin
        band_num  <= coef_index[9:5];
        band_peak <= peak_next;
        band_sum  <= sum_next;
      end
    end
  end

endmodule

/* File: verilog/hqmc_sat_cnt.sv */
// Saturating up/down streak counter held between zero and a ceiling.
`timescale 1ns/100ps
module hqmc_sat_cnt (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Control.
  input  wire logic       clear,
  input  wire logic       step,
  input  wire logic       up,
  // Value now and after the pending step.
  output logic [3:0]      count,
  output logic [3:0]      count_next
);

  // ----------------------------------------------------------------
  // Saturating step
  // ----------------------------------------------------------------
  // An increment at the ceiling or a decrement at zero leaves the value alone.
  always_comb begin
    count_next = count;
    if (step && up && (count < hqmc_pkg::CNT_MAX)) begin
      count_next = count + 4'h1;
    end else if (step && !up && (count > hqmc_pkg::CNT_RESET)) begin
      count_next = count - 4'h1;
    end
  end

  // Reset and software clear both return the streak to zero.
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      count <= hqmc_pkg::CNT_RESET;
    end else begin
      count <= count_next;
    end
  end

endmodule

/* File: verilog/hqmc_classifier.sv */
// Per-frame tonality estimator and Normal/Harmonic/Transient mode classifier.
`timescale 1ns/100ps
module hqmc_classifier (
  // Clock and reset.
  input  wire logic                               clk,
  input  wire logic                               rst,
  // Coefficient stream from the transform stage.
  input  wire logic                               coef_valid,
  input  wire logic [hqmc_pkg::IDX_W-1:0]         coef_index,
  input  wire logic signed [hqmc_pkg::COEF_W-1:0] coef_value,
  input  wire logic                               frame_transient,
  // Mode bits to the bitstream packer.
  output logic                                    mode_valid,
  output logic                                    mode_transient,
  output logic                                    mode_harmonic,
  // Wishbone register slave.
  input  wire logic                               wb_cyc_i,
  input  wire logic                               wb_stb_i,
  input  wire logic                               wb_we_i,
  input  wire logic [7:0]                         wb_adr_i,
  input  wire logic [31:0]                        wb_dat_i,
  input  wire logic [3:0]                         wb_sel_i,
  output logic [31:0]                             wb_dat_o,
  output logic                                    wb_ack_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Sub-band results.
  logic                               band_done;     // One finished sub-band.
  logic [4:0]                         band_num;      // Its index j.
  logic [hqmc_pkg::COEF_W-1:0]        band_peak;     // Its peak magnitude.
  logic [hqmc_pkg::SUM_W-1:0]         band_sum;      // Its magnitude sum.

  logic [hqmc_pkg::CMP_W-1:0]         peak_lo_scaled; // 64 times the peak.
  logic [hqmc_pkg::CMP_W-1:0]         peak_hi_scaled; // 80 times the peak.
  logic [hqmc_pkg::CMP_W-1:0]         sum_scaled;    // 9 times the sum.
  logic                               sharp_lo;      // Peakiness above 4.5.
  logic                               sharp_hi;      // Peakiness above 3.6.

  logic [3:0]                         lo_cnt_reg;    // Tonal low sub-bands this frame.
  logic [3:0]                         hi_cnt_reg;    // Tonal high sub-bands this frame.
  logic                               frame_end_reg; // Last sub-band just counted.
  logic                               trans_reg;     // Transient flag of the frame.
  logic                               tonal;         // Frame meets the tonal test.
  logic                               eligible;      // Operating point allows Harmonic.
  logic                               estimate;      // Run the streak update.
  logic                               harm_decision; // Harmonic outcome before gating.

  // Streak counters.
  logic [3:0]                         harm_streak;
  // Only the non-harmonic streak needs its look-ahead.
  logic [3:0]                         nonharm_streak;
  logic [3:0]                         nonharm_streak_next;

  logic [1:0]                         bw_reg;        // Bandwidth setting.
  logic [1:0]                         rate_reg;      // Bit rate setting.
  logic [1:0]                         fs_reg;        // Input sample rate setting.
  logic                               clr_reg;       // One-cycle streak clear.
  logic [3:0]                         last_lo_reg;   // Low count of the last frame.
  logic [3:0]                         last_hi_reg;   // High count of the last frame.
  logic                               last_tonal_reg; // Tonal test of the last frame.
  logic [15:0]                        frames_reg;    // Frames classified, wraps.

  logic                               wb_req;        // Bus request present.
  logic [31:0]                        rd_data;       // Read mux.

  // ----------------------------------------------------------------
  // Sub-band accumulation
  // ----------------------------------------------------------------
  hqmc_band_acc u_band_acc (
    .clk        (clk),
    .rst        (rst),
    .coef_valid (coef_valid),
    .coef_index (coef_index),
    .coef_value (coef_value),
    .band_done  (band_done),
    .band_num   (band_num),
    .band_peak  (band_peak),
    .band_sum   (band_sum)
  );

  // ----------------------------------------------------------------
  // Sharpness tests
  // ----------------------------------------------------------------
  // Cross-multiplying avoids a divider: 32*peak/sum > T is tested as
  // num*peak > den*sum. A zero sum forces a zero peak, so both tests fail,
  // which is exactly the zero peakiness the estimator calls for.
  // 26 bits hold nine times the largest sum.
  assign peak_lo_scaled = 26'(band_peak) * 26'(hqmc_pkg::LO_NUM);
  assign peak_hi_scaled = 26'(band_peak) * 26'(hqmc_pkg::HI_NUM);
  assign sum_scaled     = 26'(band_sum) * 26'(hqmc_pkg::SUM_DEN);
  assign sharp_lo = (peak_lo_scaled > sum_scaled);
  // The peak floor is strict.
  assign sharp_hi = (peak_hi_scaled > sum_scaled)
                    && (band_peak > hqmc_pkg::PEAK_MIN);

  // ----------------------------------------------------------------
  // Tonal band counts
  // ----------------------------------------------------------------
  // Counts restart after every frame end so each frame starts from zero.
  always_ff @(posedge clk) begin
    if (rst || frame_end_reg) begin
      lo_cnt_reg <= 4'h0;
      hi_cnt_reg <= 4'h0;
    end else if (band_done) begin
      // Low group, bands 3..7.
      if ((band_num < 5'(hqmc_pkg::BAND_SPLIT)) && sharp_lo) begin
        lo_cnt_reg <= lo_cnt_reg + 4'h1;
      end
      // High group, bands 8..16.
      if ((band_num >= 5'(hqmc_pkg::BAND_SPLIT)) && sharp_hi) begin
        hi_cnt_reg <= hi_cnt_reg + 4'h1;
      end
    end
  end

  // The frame closes once sub-band 16 is counted; transient is taken with it.
  always_ff @(posedge clk) begin
    if (rst) begin
      frame_end_reg <= 1'b0;
      trans_reg     <= 1'b0;
    end else begin
      // Band 16 done: all 448 are in.
      frame_end_reg <= band_done && (band_num == 5'(hqmc_pkg::BAND_LAST));
      // Flag rides on index 543 only.
      if (coef_valid && (coef_index == hqmc_pkg::IDX_LAST)) begin
        trans_reg <= frame_transient;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame decision
  // ----------------------------------------------------------------
  // Counts are final at frame end.
  assign tonal = ((5'(lo_cnt_reg) + 5'(hi_cnt_reg)) >= 5'(hqmc_pkg::TOTAL_MIN))
                 && (hi_cnt_reg > hqmc_pkg::HIGH_MIN);

  // Harmonic mode exists only for SWB/FB at 13.2 or 16.4 kbps with
  // 32/48 kHz input. Everything else, including narrowband, is Normal or Transient.
  assign eligible = ((bw_reg == hqmc_pkg::BW_SWB) || (bw_reg == hqmc_pkg::BW_FB))
                    && ((rate_reg == hqmc_pkg::RATE_13K2)
                        || (rate_reg == hqmc_pkg::RATE_16K4))
                    && (fs_reg != hqmc_pkg::FS_8K) && (fs_reg != hqmc_pkg::FS_16K)
                    && (bw_reg != hqmc_pkg::BW_NB);

  // Streaks move only on frames that pass through the estimator.
  // Transient frames never touch them.
  assign estimate = frame_end_reg && eligible && !trans_reg;

  // A clear beats a step in one cycle.
  hqmc_sat_cnt u_harm_cnt (
    .clk        (clk),
    .rst        (rst),
    .clear      (clr_reg),
    .step       (estimate),
    .up         (tonal),
    .count      (harm_streak),
    .count_next ()
  );

  // Mirror of the harmonic streak.
  hqmc_sat_cnt u_nonharm_cnt (
    .clk        (clk),
    .rst        (rst),
    .clear      (clr_reg),
    .step       (estimate),
    .up         (!tonal),
    .count      (nonharm_streak),
    .count_next (nonharm_streak_next)
  );

  // The decision looks at the non-harmonic streak after this frame's step.
  // Five or more is Harmonic regardless.
  assign harm_decision = ((nonharm_streak_next < hqmc_pkg::NONHARM_LIM) && tonal)
                         || (nonharm_streak_next >= hqmc_pkg::NONHARM_LIM);

  // Mode bits change only at frame end and hold until the next one.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_valid     <= 1'b0;
      mode_transient <= 1'b0;
      mode_harmonic  <= 1'b0;
    end else begin
      mode_valid <= frame_end_reg;
      // Ineligible frames give Normal, or Transient when the frame is flagged transient.
      if (frame_end_reg) begin
        mode_transient <= trans_reg;
        mode_harmonic  <= estimate && harm_decision;
      end
    end
  end

  // Snapshot of the last frame for software.
  // Taken before the counts reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      last_lo_reg    <= 4'h0;
      last_hi_reg    <= 4'h0;
      last_tonal_reg <= 1'b0;
      frames_reg     <= 16'h0000;
    end else if (frame_end_reg) begin
      last_lo_reg    <= lo_cnt_reg;
      last_hi_reg    <= hi_cnt_reg;
      last_tonal_reg <= tonal;
      frames_reg     <= frames_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Ack comes one cycle after the request and drops the next cycle. Writes
  // land on the edge where the master sees ack, so a request withdrawn
  // early never writes.
  assign wb_req = wb_cyc_i && wb_stb_i;

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      // Never high two cycles in a row.
      wb_ack_o <= wb_req && !wb_ack_o;
    end
  end

  // Configuration writes; byte lane 0 holds settings, lane 1 the clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      bw_reg   <= hqmc_pkg::CTRL_BW_RST;
      rate_reg <= hqmc_pkg::CTRL_RATE_RST;
      fs_reg   <= hqmc_pkg::CTRL_FS_RST;
      clr_reg  <= 1'b0;
    end else begin
      // The clear pulse lasts one cycle.
      clr_reg <= 1'b0;
      if (wb_req && wb_ack_o && wb_we_i && (wb_adr_i == hqmc_pkg::ADR_CTRL)) begin
        if (wb_sel_i[0]) begin
          bw_reg   <= wb_dat_i[hqmc_pkg::CTRL_BW_POS +: 2];
          rate_reg <= wb_dat_i[hqmc_pkg::CTRL_RATE_POS +: 2];
          fs_reg   <= wb_dat_i[hqmc_pkg::CTRL_FS_POS +: 2];
        end
        // Lane 1: clear only.
        if (wb_sel_i[1]) begin
          clr_reg <= wb_dat_i[hqmc_pkg::CTRL_CLR_POS];
        end
      end
    end
  end

  // Read mux; unmapped addresses read as zero and are still acknowledged.
  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      hqmc_pkg::ADR_CTRL: begin
        // Settings.
        rd_data = {26'h000_0000, fs_reg, rate_reg, bw_reg};
      end
      hqmc_pkg::ADR_STATUS: begin
        // Streaks, counts, mode.
        rd_data = {13'h0000, last_tonal_reg, mode_harmonic, mode_transient,
                   last_hi_reg, last_lo_reg, nonharm_streak, harm_streak};
      end
      hqmc_pkg::ADR_FRAMES: begin
        // Frame count.
        rd_data = {16'h0000, frames_reg};
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // Read data is taken with the request and stands with the ack
  // until the next request.
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_ack_o) begin
      wb_dat_o <= rd_data;
    end
  end

endmodule

/* File: tb/hqmc_classifier_properties.sv */
// Concurrent checks on the mode classifier ports, bound into the design.
`timescale 1ns/100ps
module hqmc_classifier_properties (
  // Clock and reset.
  input wire logic                               clk,
  input wire logic                               rst,
  // Coefficient stream and mode bits.
  input wire logic                               coef_valid,
  input wire logic [hqmc_pkg::IDX_W-1:0]         coef_index,
  input wire logic                               frame_transient,
  input wire logic                               mode_valid,
  input wire logic                               mode_transient,
  input wire logic                               mode_harmonic,
  // Register bus handshake.
  input wire logic                               wb_cyc_i,
  input wire logic                               wb_stb_i,
  input wire logic                               wb_ack_o
);
  // ----------------------------------------------------------------
  // Properties, all in the one clock domain.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // The last analysed coefficient closes the frame three cycles later.
  property p_end_lat;
    coef_valid && coef_index == hqmc_pkg::IDX_LAST |-> ##3 mode_valid;
  endproperty
  a_end_lat: assert property (p_end_lat) else $error("decision late");
  property p_no_early;
    mode_valid |-> $past(coef_valid && coef_index == hqmc_pkg::IDX_LAST, 3);
  endproperty
  a_no_early: assert property (p_no_early) else $error("decision without frame end");
  property p_pulse;
    mode_valid |=> !mode_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("decision pulse too long");
  property p_hold;
    !mode_valid |-> $stable(mode_transient) && $stable(mode_harmonic);
  endproperty
  a_hold: assert property (p_hold) else $error("mode bits moved");
  property p_trans_normal;
    mode_valid && mode_transient |-> !mode_harmonic;
  endproperty
  a_trans_normal: assert property (p_trans_normal) else $error("transient harmonic");
  property p_trans_src;
    mode_valid |-> mode_transient == $past(frame_transient, 3);
  endproperty
  a_trans_src: assert property (p_trans_src) else $error("transient bit wrong");
  // A taken bus request is acknowledged on the very next edge, once.
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  c_harm: cover property (mode_valid && mode_harmonic);
  c_norm: cover property (mode_valid && !mode_harmonic && !mode_transient);
  c_trans: cover property (mode_valid && mode_transient);
endmodule
bind hqmc_classifier hqmc_classifier_properties chk_u (.clk, .rst, .coef_valid, .coef_index,
  .frame_transient, .mode_valid, .mode_transient, .mode_harmonic, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o);

/* File: tb/hqmc_coef_source.sv */
// Transform stage model: streams one frame of analysed coefficients with random gaps.
`timescale 1ns/100ps
module hqmc_coef_source (
  // Clock and reset.
  input wire logic         clk,
  input wire logic         rst,
  // Frame request from the bench.
  input wire logic         start,
  input wire logic         tonal,
  input wire logic         trans,
  input wire logic [15:0]  amp,
  output logic             busy,
  // Coefficient stream.
  output logic             coef_valid,
  output logic [9:0]       coef_index,
  output logic signed [15:0] coef_value,
  output logic             frame_transient
);
  logic [9:0] nxt; // Next index to send.
  // ----------------------------------------------------------------
  // Stream: tonal frames put one spike of -amp per band, flat ones amp everywhere.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      busy       <= 1'b0;
      coef_valid <= 1'b0;
    end else if (!busy) begin
      coef_valid      <= 1'b0;
      coef_index      <= ~coef_index; // Released lines do not keep the last value.
      coef_value      <= ~coef_value;
      frame_transient <= ~frame_transient;
      busy            <= start;
      nxt             <= hqmc_pkg::IDX_FIRST;
    end else if ($urandom_range(0, 3) == 0) begin
      coef_valid <= 1'b0; // Idle gap inside the frame.
    end else begin
      coef_valid      <= 1'b1;
      coef_index      <= nxt;
      coef_value      <= tonal ? ((nxt[4:0] == 5'h05) ? -$signed(amp) : 16'h0000) : amp;
      frame_transient <= trans;
      nxt             <= nxt + 10'h001;
      busy            <= (nxt != hqmc_pkg::IDX_LAST);
    end
  end
endmodule

/* File: tb/test_hqmc_classifier.sv */
// Self-checking bench for the harmonic mode classifier.
`timescale 1ns/100ps
module test_hqmc_classifier;
  logic clk = 1'b0, rst = 1'b1, st = 1'b0, tn = 1'b0, tr = 1'b0;
  logic [15:0] am = 16'h0000;
  logic cv, ft, busy, mv, mt, mh, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [9:0] ci;
  logic signed [15:0] cval;
  logic [7:0] adr = 8'h00;
  logic [31:0] dw = 32'h0, dr, r;
  logic [1:0] expq[$]; // Expected {transient, harmonic} per frame.
  int miscompares = 0, n_checks = 0, hs = 0, ns = 0, i;
  logic [31:0] ctrl_v = 32'h0000_002A;
  always #20 clk = ~clk;
  hqmc_coef_source src_u (.clk(clk), .rst(rst), .start(st), .tonal(tn), .trans(tr), .amp(am),
    .busy(busy), .coef_valid(cv), .coef_index(ci), .coef_value(cval), .frame_transient(ft));
  hqmc_classifier dut_u (.clk(clk), .rst(rst), .coef_valid(cv), .coef_index(ci),
    .coef_value(cval), .frame_transient(ft), .mode_valid(mv), .mode_transient(mt),
    .mode_harmonic(mh), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dw), .wb_sel_i(4'hF), .wb_dat_o(dr), .wb_ack_o(ack));
  // ----------------------------------------------------------------
  // Compare, report and bus tasks.
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp_reg(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %0t register %h not %h", $time, g, e);
    end
  endtask
  task automatic cmp_mode(input logic [1:0] e, input logic [1:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %0t mode %b not %b", $time, g, e);
    end
  endtask
  // One classic cycle; read data is taken at the edge that samples ack high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d;
    do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin miscompares++; end_sim(); end
    r = dr;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
    if (w && a == 8'h00) ctrl_v = d & 32'h0000_003F;
    if (w && a == 8'h00 && d[8]) begin hs = 0; ns = 0; end
  endtask
  // One frame: predicts the streaks and the mode, then streams it and waits for the decision.
  task automatic frame(input logic t, input logic [15:0] a, input logic x);
    logic ton, el;
    int k;
    ton = t && (a > 16'h000A);
    el = ctrl_v[1:0] >= 2 && ctrl_v[3:2] >= 2 && ctrl_v[5:4] >= 2 && !x;
    if (el && ton) begin hs = (hs < 8) ? hs + 1 : hs; ns = (ns > 0) ? ns - 1 : ns; end
    if (el && !ton) begin hs = (hs > 0) ? hs - 1 : hs; ns = (ns < 8) ? ns + 1 : ns; end
    expq.push_back({x, el && ((ns < 5 && ton) || ns >= 5)});
    tn <= t; am <= a; tr <= x; st <= 1'b1;
    @(posedge clk);
    st <= 1'b0;
    for (k = 0; k < 5000 && expq.size() != 0; k++) @(posedge clk);
    if (k >= 5000) begin miscompares++; end_sim(); end
  endtask
  // Decision watcher takes the oldest prediction at each mode pulse.
  always @(negedge clk) begin
    if (rst === 1'b0 && mv === 1'b1) begin
      if (expq.size() == 0) begin miscompares++; $display("unexpected %0t decision", $time); end
      else cmp_mode(expq.pop_front(), {mt, mh});
    end
  end
  initial begin
    void'($urandom(97));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, 8'h00, 32'h0); cmp_reg(32'h0000_002A, r);
    wb(1'b0, 8'h04, 32'h0); cmp_reg(32'h0, r);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF); wb(1'b0, 8'h0C, 32'h0); cmp_reg(32'h0, r);
    for (i = 0; i < 10; i++) frame(1'b1, 16'h0064, 1'b0);
    for (i = 0; i < 7; i++) frame(1'b0, 16'h0001, 1'b0);
    wb(1'b0, 8'h04, 32'h0); cmp_reg(32'h0002_0000 + 32'(ns * 16 + hs), r);
    for (i = 0; i < 6; i++) frame(1'($urandom), 16'($urandom_range(0, 40)), 1'($urandom));
    wb(1'b1, 8'h00, 32'h0); frame(1'b1, 16'h0064, 1'b0);
    wb(1'b1, 8'h00, 32'h0000_001A); frame(1'b1, 16'h0064, 1'b0);
    wb(1'b1, 8'h00, 32'h0000_012A); wb(1'b0, 8'h04, 32'h0); cmp_reg(32'h0, r & 32'h0000_00FF);
    frame(1'b1, 16'h000B, 1'b0); frame(1'b1, 16'h000A, 1'b0); frame(1'b1, 16'h0000, 1'b0);
    wb(1'b0, 8'h08, 32'h0); cmp_reg(32'h0000_001C, r);
    end_sim();
  end
endmodule
